// *** src/dmr_pkg.sv ***
// constants, types and register map of the diagnostic message reassembler
// assumes a single 250 MHz clock domain and a 32-bit APB register bus
package dmr_pkg;
  // ***********************************************************************
  // register map and bus widths
  // ***********************************************************************
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam logic [7:0]  STATUS_OFS    = 8'h00;
  localparam logic [7:0]  DATA_OFS      = 8'h04;
  localparam logic [7:0]  IRQ_STAT_OFS  = 8'h08;
  localparam logic [7:0]  IRQ_MASK_OFS  = 8'h0C;
  // status register fields
  localparam int unsigned ST_AVAIL      = 0;
  localparam int unsigned ST_MSG        = 1;
  localparam int unsigned ST_LOCK       = 2;
  localparam int unsigned ST_NOT_EMPTY  = 3;
  localparam int unsigned ST_FULL       = 4;
  localparam int unsigned ST_W          = 5;
  // interrupt status and mask fields
  localparam int unsigned IRQ_DONE      = 0;
  localparam int unsigned IRQ_ABORT     = 1;
  localparam int unsigned IRQ_DROP      = 2;
  localparam int unsigned IRQ_LOCK      = 3;
  localparam int unsigned IRQ_W         = 4;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
  // ***********************************************************************
  // receive path and buffer geometry
  // ***********************************************************************
  localparam int unsigned DET_W         = 13;
  localparam int unsigned TAP_POS       = 7;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned SLICE_W       = 4;
  localparam int unsigned SLICES        = 4;
  localparam int unsigned DEPTH         = 16;
  localparam int unsigned PTR_W         = 4;
  localparam logic [4:0]  FIFO_FULL_CNT = 5'h10;
  localparam logic [7:0]  IDLE_PAT      = 8'h7E;
  localparam logic [7:0]  ABORT_PAT     = 8'hFF;
  localparam logic [6:0]  STUFF_PAT     = 7'h3E;
  localparam logic [3:0]  LOCK_PRESET   = 4'h9;
  localparam logic [3:0]  LOCK_MAX      = 4'hF;
  localparam logic [7:0]  PAD_BYTE      = 8'h00;

  typedef struct packed {
    logic abort;
    logic idle;
    logic skip;
  } dmr_rx_evt_t;

  typedef enum logic {DMR_IDLE = 1'b0, DMR_MSG = 1'b1} dmr_msg_t;
  typedef enum logic {DMR_UPPER = 1'b0, DMR_LOWER = 1'b1} dmr_half_t;
endpackage : dmr_pkg

// *** src/dmr_sync.sv ***
// two-flop synchroniser for levels arriving from outside the clock domain
// assumes inputs are plain levels; the first stage feeds only the second
`timescale 1ns/100ps
module dmr_sync import dmr_pkg::*; #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // plain two-stage capture, reset to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : dmr_sync

// *** src/dmr_fifo_slice.sv ***
// one 4-bit wide, 16-entry first-in first-out slice of the output buffer
// assumes the caller never relies on a push when full or a pop when empty
`timescale 1ns/100ps
module dmr_fifo_slice import dmr_pkg::*; (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wr_i,
  input  wire logic [SLICE_W-1:0] din_i,
  input  wire logic               rd_i,
  output logic      [SLICE_W-1:0] dout_o,
  output logic                    full_o,
  output logic                    empty_o
);
  logic [SLICE_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]   wptr;
  logic [PTR_W-1:0]   rptr;
  logic [PTR_W:0]     cnt;
  logic               push;
  logic               pop;

  // guarded strobes keep the pointers honest at either limit
  assign full_o  = (cnt == FIFO_FULL_CNT);
  assign empty_o = (cnt == '0);
  assign push    = wr_i & ~full_o;
  assign pop     = rd_i & ~empty_o;
  assign dout_o  = mem[rptr];

  // storage, no reset needed: only read behind the count
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr] <= din_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr <= '0;
      rptr <= '0;
      cnt  <= '0;
    end else begin
      if (push) wptr <= wptr + 4'h1;
      if (pop) rptr <= rptr + 4'h1;
      case ({push, pop})
        2'b10:   cnt <= cnt + 5'h01;
        2'b01:   cnt <= cnt - 5'h01;
        default: cnt <= cnt;
      endcase
    end
  end
endmodule : dmr_fifo_slice

// *** src/dmr_top.sv ***
// diagnostic message reassembler: looped-back bit stream to 16-bit words
// assumes an APB master on clk_i and a link clock far slower than clk_i
//
// How it works
// RULE1: sixteen-word buffer from four 4-bit slices
// RULE2: upper and lower halves share byte register
// RULE3: controller reads words via data command
// RULE4: read pulse through two flops: drive, pop
// RULE5: abort, idle, skip and empty steer assembly; the code steers it with abort, idle and skip only
// RULE6: abort clears available, progress and lock
// RULE7: first idle presets counter to nine
// RULE8: registered carry gives lock pulse, sets lock
// RULE9: lock pulse re-presets counter every byte
// RULE10: idles at lock pulse keep progress idle
// RULE11: lock pulse without idle marks start
// RULE12: start sets progress, enables half gates
// RULE13: one half at a time, upper first
// RULE14: each byte written, then half toggles
// RULE15: closing idle writes lower, flags data
// RULE16: byte register taps eighth detect stage
// RULE17: stuffing pattern gates byte register shift
// RULE18: writes into a full buffer are dropped
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module dmr_top import dmr_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              link_clk_i,
  input  wire logic              link_data_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   irq_o
);
  // ***********************************************************************
  // link sampling and receive shift registers
  // ***********************************************************************
  logic [1:0]        link_sync;
  logic              link_clk_q;
  logic              bit_tick;
  logic              tick_d;
  logic [DET_W-1:0]  detect_shift_register;
  logic [BYTE_W-1:0] byte_shift_register;
  logic              skip_armed;
  logic              gated_byte_clock;
  logic              step_en;
  dmr_rx_evt_t       rx_evt;
  dmr_msg_t          message_in_progress_flag;

  dmr_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link_clk_i, link_data_i}),
    .q_o   (link_sync)
  );

  // rising edge of the sampled link clock; data is stable around it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_clk_q <= 1'b0;
      bit_tick   <= 1'b0;
      tick_d     <= 1'b0;
    end else begin
      link_clk_q <= link_sync[1];
      bit_tick   <= link_sync[1] & ~link_clk_q;
      tick_d     <= bit_tick;
    end
  end

  // newest bit enters at index 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detect_shift_register <= '0;
    end else if (bit_tick) begin
      detect_shift_register <= {detect_shift_register[DET_W-2:0],
                                link_sync[0]};
    end
  end

  // frame decode one cycle after each shift
  assign rx_evt.abort = tick_d &
    (detect_shift_register[BYTE_W-1:0] == ABORT_PAT);
  assign rx_evt.idle  = tick_d &
    (detect_shift_register[BYTE_W-1:0] == IDLE_PAT);
  assign rx_evt.skip  = tick_d & skip_armed;                     // RULE5

  // the stuffed zero sits one stage short of the tap when matched,
  // so the gate is armed now and used on the following step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_armed <= 1'b0;
    end else if (tick_d) begin
      skip_armed <= (message_in_progress_flag == DMR_MSG) &&
        (detect_shift_register[DET_W-1 -: 7] == STUFF_PAT);      // RULE17
    end
  end

  // a stripped bit also stalls the byte cadence, keeping alignment
  assign step_en          = tick_d & ~rx_evt.skip;
  assign gated_byte_clock = step_en;                             // RULE17

  // first received bit ends up in the byte's top bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_shift_register <= '0;
    end else if (gated_byte_clock) begin
      byte_shift_register <= {byte_shift_register[BYTE_W-2:0],
                              detect_shift_register[TAP_POS]};   // RULE16
    end
  end

  // ***********************************************************************
  // idle lock and message sequencing
  // ***********************************************************************
  logic [3:0] lock_counter;
  logic       ripple_carry;
  logic       carry_register_flop;
  logic       lock_evt;
  logic       idle_lock_flag;
  logic       data_available_flag;
  dmr_half_t  half_select_toggle;
  logic       start_evt;
  logic       mid_evt;
  logic       end_evt;

  assign ripple_carry = (lock_counter == LOCK_MAX);
  assign lock_evt     = step_en & carry_register_flop;
  assign start_evt    = lock_evt & ~rx_evt.idle & idle_lock_flag &
                        (message_in_progress_flag == DMR_IDLE);  // RULE11
  assign mid_evt      = lock_evt & ~rx_evt.idle &
                        (message_in_progress_flag == DMR_MSG);
  assign end_evt      = lock_evt & rx_evt.idle &
                        (message_in_progress_flag == DMR_MSG);

  // counter parks at zero until an idle frame primes it
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_evt.abort) begin
      lock_counter <= '0;
    end else if (step_en) begin
      if (lock_evt) begin
        lock_counter <= LOCK_PRESET;                             // RULE9
      end else if (rx_evt.idle && !idle_lock_flag) begin
        lock_counter <= LOCK_PRESET;                             // RULE7
      end else if (lock_counter != '0) begin
        lock_counter <= lock_counter + 4'h1;
      end
    end
  end

  // carry registered once: the lock pulse lands on the idle slot
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_evt.abort) begin
      carry_register_flop <= 1'b0;
    end else if (step_en) begin
      carry_register_flop <= ripple_carry;                       // RULE8
    end
  end

  // lock state
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_evt.abort) begin
      idle_lock_flag <= 1'b0;                                    // RULE6
    end else if (lock_evt) begin
      idle_lock_flag <= 1'b1;                                    // RULE8
    end
  end

  // message state; repeated idles simply leave it idle
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_evt.abort) begin
      message_in_progress_flag <= DMR_IDLE;                      // RULE6
    end else begin
      case (message_in_progress_flag)
        DMR_IDLE: begin
          if (start_evt) message_in_progress_flag <= DMR_MSG;    // RULE12
        end
        DMR_MSG: begin
          if (end_evt) message_in_progress_flag <= DMR_IDLE;     // RULE15
        end
        default: message_in_progress_flag <= DMR_IDLE;
      endcase
    end
  end

  // half select: upper first, flips on each byte of the message
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_evt.abort) begin
      half_select_toggle <= DMR_UPPER;
    end else if (start_evt || end_evt) begin
      half_select_toggle <= DMR_UPPER;                           // RULE13
    end else if (mid_evt) begin
      half_select_toggle <= (half_select_toggle == DMR_UPPER) ?
                            DMR_LOWER : DMR_UPPER;               // RULE14
    end
  end

  // set by a finished message; the set wins over an abort clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_available_flag <= 1'b0;
    end else if (end_evt) begin
      data_available_flag <= 1'b1;                               // RULE15
    end else if (rx_evt.abort) begin
      data_available_flag <= 1'b0;                               // RULE6
    end
  end

  // ***********************************************************************
  // output buffer and write gates
  // ***********************************************************************
  logic [SLICES-1:0]  sl_full;
  logic [SLICES-1:0]  sl_empty;
  logic [WORD_W-1:0]  head_word;
  logic [WORD_W-1:0]  word_in;
  logic [BYTE_W-1:0]  upper_byte;
  logic               wr_upper;
  logic               wr_lower;
  logic               drop_up;
  logic               push_up;
  logic               push_lo;
  logic               pair_drop;
  logic               drop_evt;
  logic               pop;
  logic               fifo_empty_n;
  logic               rd_stage1;
  logic               rd_stage2;

  // an odd-length message closes with a zero upper byte so that
  // both halves hold the same number of entries once each message has closed
  assign wr_upper   = (mid_evt || end_evt) &&
                      (half_select_toggle == DMR_UPPER);         // RULE14
  assign wr_lower   = (mid_evt && half_select_toggle == DMR_LOWER) ||
                      end_evt;                                   // RULE15
  assign upper_byte = end_evt ? PAD_BYTE : byte_shift_register;
  assign word_in    = {upper_byte, byte_shift_register};         // RULE2
  assign drop_up    = wr_upper & sl_full[SLICES-1];
  assign push_up    = wr_upper & ~sl_full[SLICES-1];             // RULE18
  assign push_lo    = wr_lower & ~sl_full[0] &
                      ~(pair_drop | drop_up);                    // RULE18
  assign drop_evt   = (wr_upper | wr_lower) & ~(push_up | push_lo);
  assign fifo_empty_n = ~sl_empty[0];
  assign pop        = rd_stage2 & fifo_empty_n;                  // RULE4

  // a dropped upper byte takes its lower partner with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_drop <= 1'b0;
    end else if (wr_lower) begin
      pair_drop <= 1'b0;
    end else if (drop_up) begin
      pair_drop <= 1'b1;
    end
  end

  // two upper slices, two lower slices
  for (genvar i = 0; i < SLICES; i++) begin : g_slice
    dmr_fifo_slice u_slice (                                     // RULE1
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .wr_i    ((i >= SLICES / 2) ? push_up : push_lo),
      .din_i   (word_in[i*SLICE_W +: SLICE_W]),
      .rd_i    (pop),
      .dout_o  (head_word[i*SLICE_W +: SLICE_W]),
      .full_o  (sl_full[i]),
      .empty_o (sl_empty[i])
    );
  end

  // ***********************************************************************
  // APB slave, read command pipeline and interrupts
  // ***********************************************************************
  logic              setup_ph;
  logic              access_ph;
  logic              mapped;
  logic              is_data_rd;
  logic              read_word_pulse_n;
  logic              wr_stat;
  logic              wr_mask;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [ST_W-1:0]   status_val;
  logic [DATA_W-1:0] rd_mux;
  logic              lock_rise;

  assign setup_ph   = psel_i & ~penable_i;
  assign access_ph  = psel_i & penable_i;
  assign mapped     = (paddr_i == STATUS_OFS) || (paddr_i == DATA_OFS) ||
                      (paddr_i == IRQ_STAT_OFS) ||
                      (paddr_i == IRQ_MASK_OFS);
  assign is_data_rd = ~pwrite_i & (paddr_i == DATA_OFS);
  // the read command is decoded once per data-register access
  assign read_word_pulse_n = ~(access_ph & is_data_rd &
                               ~rd_stage1 & ~rd_stage2);         // RULE3
  assign pready_o   = ~is_data_rd | rd_stage2;
  assign pslverr_o  = access_ph & ~mapped;
  assign wr_stat    = access_ph & pwrite_i & (paddr_i == IRQ_STAT_OFS);
  assign wr_mask    = access_ph & pwrite_i & (paddr_i == IRQ_MASK_OFS);

  // read pulse through two flops: first drives data, second pops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_stage1 <= 1'b0;
      rd_stage2 <= 1'b0;
    end else begin
      rd_stage1 <= ~read_word_pulse_n;                           // RULE4
      rd_stage2 <= rd_stage1;                                    // RULE4
    end
  end

  assign status_val = {sl_full[0], fifo_empty_n, idle_lock_flag,
                       message_in_progress_flag == DMR_MSG,
                       data_available_flag};

  // register read value, chosen in the setup cycle
  always_comb begin
    rd_mux = '0;
    case (paddr_i)
      STATUS_OFS:   rd_mux[ST_W-1:0]  = status_val;
      IRQ_STAT_OFS: rd_mux[IRQ_W-1:0] = irq_status;
      IRQ_MASK_OFS: rd_mux[IRQ_W-1:0] = irq_mask;
      default:      rd_mux = '0;
    endcase
  end

  // read data from flops; an empty buffer reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else if (rd_stage1) begin
      prdata_o <= fifo_empty_n ? {16'h0000, head_word} : '0;     // RULE4
    end else if (setup_ph && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask <= pwdata_i[IRQ_W-1:0];
    end
  end

  assign lock_rise = lock_evt & ~idle_lock_flag;
  assign irq_set   = {lock_rise, drop_evt, rx_evt.abort, end_evt};

  // sticky events, write one to clear, a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= irq_set |
        (irq_status & ~({IRQ_W{wr_stat}} & pwdata_i[IRQ_W-1:0]));
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // ***********************************************************************
  // checks
  // ***********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence read_pipe_s;
    rd_stage1 && !rd_stage2 ##1 rd_stage2 && !rd_stage1;
  endsequence

  sequence msg_closed_s;
    message_in_progress_flag == DMR_IDLE && data_available_flag;
  endsequence

  read_two_stage_a: assert property (                            // RULE4
    !read_word_pulse_n |=> read_pipe_s)
    else $error("read pulse did not pass two stages");
  pop_on_second_a: assert property (                             // RULE4
    rd_stage2 && fifo_empty_n |-> pop && pready_o)
    else $error("second stage did not pop the word");
  abort_clears_a: assert property (                              // RULE6
    rx_evt.abort && !end_evt |=> !data_available_flag &&
      !idle_lock_flag && message_in_progress_flag == DMR_IDLE)
    else $error("abort left a flag set");
  preset_nine_a: assert property (                               // RULE7
    rx_evt.idle && !idle_lock_flag && !rx_evt.abort |=>
      lock_counter == LOCK_PRESET)
    else $error("first idle did not preset counter");
  // the carry flop only moves on bit steps, so it is checked per step
  carry_to_lock_a: assert property (                             // RULE8
    step_en && ripple_carry && !rx_evt.abort |=> carry_register_flop)
    else $error("carry not registered");
  lock_set_a: assert property (                                  // RULE8
    lock_evt && !rx_evt.abort |=> idle_lock_flag &&
      !carry_register_flop)
    else $error("lock pulse did not lock or did not end");
  idle_holds_a: assert property (                                // RULE10
    lock_evt && rx_evt.idle && message_in_progress_flag == DMR_IDLE
      |=> message_in_progress_flag == DMR_IDLE)
    else $error("idle at lock pulse started a message");
  start_upper_a: assert property (                               // RULE13
    start_evt && !rx_evt.abort |=> message_in_progress_flag == DMR_MSG
      && half_select_toggle == DMR_UPPER)
    else $error("message did not start on upper half");
  byte_toggle_a: assert property (                               // RULE14
    mid_evt |=> half_select_toggle != $past(half_select_toggle))
    else $error("half select did not toggle");
  close_flags_a: assert property (                               // RULE15
    end_evt |-> wr_lower ##1 msg_closed_s)
    else $error("closing idle did not finish the message");
  full_drop_a: assert property (                                 // RULE18
    wr_upper && sl_full[SLICES-1] |-> !push_up && !push_lo && drop_evt)
    else $error("write into full buffer not dropped");
endmodule : dmr_top

// *** bench/dmr_link_tx.sv ***
// link transmitter model: abort, idle and zero-stuffed message bytes
// assumes the receiver takes data at the rising link clock edge
`timescale 1ns/100ps
module dmr_link_tx (
  output logic link_clk_o,
  output logic link_data_o
);
  // ***********************************************************
  // serial frame driver
  // ***********************************************************
  int ones;

  // clock stands low between frames
  initial begin
    link_clk_o  = 1'b0;
    link_data_o = 1'b0;
    ones        = 0;
  end

  // one bit, set while the clock is low, 48 ns period
  task automatic bit_out(input logic b);
    link_data_o = b;
    #24 link_clk_o = 1'b1;
    #24 link_clk_o = 1'b0;
  endtask : bit_out

  // msb first; message bytes get a zero after five ones
  task automatic send(input logic [7:0] b, input logic msg);
    #1;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (msg && ones == 5) begin
        bit_out(1'b0);
        ones = 0;
      end
    end
    link_data_o = ~link_data_o; // no stale level once released
    #3; // next send starts off the system clock edge
  endtask : send
endmodule : dmr_link_tx

// *** bench/dmr_top_tb_top.sv ***
// bench for the reassembler: apb master tasks, link model, checks
// assumes the designer's apb timing and a 48 ns link clock
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module dmr_top_tb_top import dmr_pkg::*;;
  // ***********************************************************
  // harness
  // ***********************************************************
  logic              clk, rst, psel, penable, pwrite, lclk, ldat;
  logic              pready, pslverr, irq, er;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, d;
  int                err_count, checks;

  // 250 MHz system clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  dmr_link_tx i_tx (.link_clk_o(lclk), .link_data_o(ldat));
  dmr_top i_dut (.clk_i(clk), .rst_i(rst), .link_clk_i(lclk),
    .link_data_i(ldat), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_o(irq));

  // verdict and end of run
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      conclude();
    end
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, d, er);
    `CHK(d, e)
  endtask : rdchk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, d, er);
  endtask : wr

  // n copies of one frame byte; the settle wait covers the synchroniser
  task automatic frames(input logic [7:0] b, input int n);
    repeat (n) i_tx.send(b, 1'b0);
    repeat (20) @(posedge clk);
  endtask : frames

  // main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    err_count = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdchk(STATUS_OFS, 32'h0);
    rdchk(IRQ_MASK_OFS, 32'h0);
    rdchk(DATA_OFS, 32'h0);
    apb(1'b0, 8'h10, 32'h0, d, er);
    `CHK(er, 1'b1)
    $display("test reset done");
    wr(IRQ_MASK_OFS, 32'hF);
    frames(ABORT_PAT, 2);
    frames(IDLE_PAT, 3);
    rdchk(STATUS_OFS, 32'h04);
    i_tx.send(8'hA5, 1'b1);
    i_tx.send(8'hF8, 1'b1);
    i_tx.send(8'h3C, 1'b1);
    frames(IDLE_PAT, 3);
    rdchk(STATUS_OFS, 32'h0D);
    rdchk(IRQ_STAT_OFS, 32'hB);
    #1 `CHK(irq, 1'b1)
    rdchk(DATA_OFS, 32'hA5F8);
    rdchk(DATA_OFS, 32'h003C);
    rdchk(STATUS_OFS, 32'h05);
    wr(IRQ_MASK_OFS, 32'h0);
    #1 `CHK(irq, 1'b0)
    wr(IRQ_MASK_OFS, 32'hF);
    wr(IRQ_STAT_OFS, 32'hF);
    rdchk(IRQ_STAT_OFS, 32'h0);
    $display("test message done");
    // seventeen words offered, the last one must be dropped
    for (int k = 0; k < 34; k++) i_tx.send(8'(k), 1'b1);
    frames(IDLE_PAT, 3);
    rdchk(STATUS_OFS, 32'h1D);
    rdchk(IRQ_STAT_OFS, 32'h5);
    for (int i = 0; i < 16; i++) rdchk(DATA_OFS, 32'(i*514+1));
    rdchk(DATA_OFS, 32'h0);
    wr(IRQ_STAT_OFS, 32'hF);
    $display("test fill done");
    frames(ABORT_PAT, 2);
    rdchk(STATUS_OFS, 32'h0);
    rdchk(IRQ_STAT_OFS, 32'h2);
    $display("test abort done");
    conclude();
  end
endmodule : dmr_top_tb_top
